//--- hw/brsf_defines.vh
// Register offsets, field positions, reset values and format codes for
// the branch record stack and freeze unit.
// Assumes a 32-bit classic Wishbone slave with byte addressing.
`ifndef BRSF_DEFINES_VH
`define BRSF_DEFINES_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define BRSF_DBGCTL_OFS      12'h000
`define BRSF_GCTRL_OFS       12'h004
`define BRSF_EVSEL_OFS       12'h008
`define BRSF_FIXCTL_OFS      12'h00C
`define BRSF_TOS_OFS         12'h010
`define BRSF_CAPS_OFS        12'h014
`define BRSF_MODE_OFS        12'h018
`define BRSF_STATUS_OFS      12'h01C
`define BRSF_LER_SRC_LO_OFS  12'h020
`define BRSF_LER_SRC_HI_OFS  12'h024
`define BRSF_LER_DST_LO_OFS  12'h028
`define BRSF_LER_DST_HI_OFS  12'h02C
`define BRSF_SRC_BASE_OFS    12'h400
`define BRSF_DST_BASE_OFS    12'h800

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define BRSF_DBG_REC_EN      0
`define BRSF_DBG_TRACE_EN    6
`define BRSF_DBG_FRZ_REC     11
`define BRSF_DBG_FRZ_CNT     12
`define BRSF_EVSEL_INT_EN    20
`define BRSF_FIX_INT_BIT     2
`define BRSF_FIX_FIELD_W     4
`define BRSF_MODE_EXT64      0
`define BRSF_MODE_COMPAT     1
`define BRSF_FLAG_LSB        58

// ----------------------------------------------------------------------
// Reset values and format codes
// ----------------------------------------------------------------------
`define BRSF_DBGCTL_RST      32'h0000_0000
`define BRSF_GCTRL_RST       32'h0000_0000
`define BRSF_FMT_SEG32       6'h00
`define BRSF_FMT_LIN64       6'h01
`define BRSF_FMT_EFF64       6'h02
`define BRSF_FMT_EFF64_FLAGS 6'h03
`define BRSF_FMT_PACKED32    6'h3F

`endif

//--- hw/brsf_top.v
// Branch record stack with freeze-on-interrupt control and last
// exception record. Registers reached over classic Wishbone, 32-bit.
// Assumes core events arrive synchronous to clk_i, one cycle each.
//
// Notes on behaviour
// RL1: Freeze-record bit set: interrupt request clears recording enable bit 0.
// RL2: Software must set recording enable again after a freeze.
// RL3: Software writes debug control carefully to avoid re-enabling by accident.
// RL4: Freeze-counter bit set: interrupt request clears all global counter enables.
// RL5: Software writes ones to counter enables before leaving the handler.
// RL6: General counter overflow with event-select bit 20 raises the interrupt.
// RL7: Fixed counter overflow with third bit of its field raises the interrupt.
// RL8: Precise sampling buffer reaching threshold raises the interrupt.
// RL9: Branch trace buffer reaching threshold raises the interrupt.
// RL10: Stack depth N is 16, 8 or 4; pointer spans 0 to N-1.
// RL11: Every instruction pointer change is recorded, not only branches. The code does not record debug exceptions.
// RL12: N source registers and N destination registers, each consecutive.
// RL13: Low bits of top pointer name the newest recorded entry.
// RL14: Records are 64 bits; only low 32 kept outside extended mode.
// RL15: Compatibility sub-mode clears upper 32 bits; full mode keeps 64.
// RL16: Read-only capability bits [5:0] report the record format.
// RL17: Format 3 stores effective addresses with flags in source upper bits.
// RL18: Packed 32-bit format holds destination high, source low.
// RL19: Separate last exception record holds branch before exception delivery.
// RL20: Exception record is 64 bits with the same mode truncation.
// RL21: With recording enabled, branches, interrupts, exceptions recorded, not debug.
// RL22: Debug exception clears recording enable; stored entries stay.
// RL23: Trace enable alone keeps the stack updating.
// RL24: New record advances pointer modulo N, then writes that entry.
`timescale 1ns/10ps
`include "brsf_defines.vh"

module brsf_top #(
  parameter       DEPTH      = 16,
  parameter       NUM_GP     = 4,
  parameter       NUM_FIX    = 3,
  parameter [5:0] REC_FORMAT = `BRSF_FMT_LIN64,
  parameter       FLAG_W     = 6
) (
  input  wire                 clk_i,
  input  wire                 rst_i,
  // Classic Wishbone slave, 32-bit data, byte addresses
  input  wire                 wb_cyc_i,
  input  wire                 wb_stb_i,
  input  wire                 wb_we_i,
  input  wire [11:0]          wb_adr_i,
  input  wire [3:0]           wb_sel_i,
  input  wire [31:0]          wb_dat_i,
  output reg  [31:0]          wb_dat_o,
  output reg                  wb_ack_o,
  // Instruction pointer changes from the core
  input  wire                 ip_change_i,
  input  wire                 is_exception_i,
  input  wire                 is_debug_exc_i,
  input  wire [63:0]          src_addr_i,
  input  wire [63:0]          dst_addr_i,
  input  wire [FLAG_W-1:0]    rec_flags_i,
  // Interrupt sources
  input  wire [NUM_GP-1:0]    gp_overflow_i,
  input  wire [NUM_FIX-1:0]   fix_overflow_i,
  input  wire                 sampling_thresh_i,
  input  wire                 trace_thresh_i,
  // Freeze and status outputs
  output reg                  perf_monitor_interrupt_o,
  output reg  [31:0]          global_counter_control_o,
  output reg                  branch_record_stack_en_o
);

  localparam PW = (DEPTH > 8) ? 4 : ((DEPTH > 4) ? 3 : 2);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Shapes an address for the active mode: low half only outside
  // extended mode, upper half cleared in compatibility sub-mode.
  function [63:0] brsf_shape;
    input [63:0] a;
    input        ext;
    input        compat;
    begin
      if (!ext || compat)
        brsf_shape = {32'h0000_0000, a[31:0]};
      else
        brsf_shape = a;
    end
  endfunction

  function [31:0] brsf_merge;
    input [31:0] old;
    input [31:0] wd;
    input [3:0]  sel;
    integer k;
    begin
      brsf_merge = old;
      for (k = 0; k < 4; k = k + 1)
        if (sel[k])
          brsf_merge[k*8 +: 8] = wd[k*8 +: 8];
    end
  endfunction

  // Event select k sits one 256-byte page above event select k-1.
  function brsf_evsel_hit;
    input [11:0] adr;
    input integer idx;
    reg   [11:0] base;
    begin
      base           = `BRSF_EVSEL_OFS + {idx[3:0], 8'h00};
      brsf_evsel_hit = (adr == base);
    end
  endfunction

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  reg [63:0]          src_mem [0:DEPTH-1];
  reg [63:0]          dst_mem [0:DEPTH-1];
  reg [PW-1:0]        top_of_stack_pointer;
  reg [31:0]          debug_ctl;
  reg [31:0]          evsel [0:NUM_GP-1];
  reg [31:0]          fix_ctl;
  reg [1:0]           mode;
  reg [63:0]          last_src;
  reg [63:0]          last_dst;
  reg [63:0]          ler_src;
  reg [63:0]          ler_dst;
  reg [3:0]           pmi_cause;
  reg [NUM_GP-1:0]    gp_int_en;
  reg [NUM_FIX-1:0]   fix_int_en;
  reg [63:0]          rec_src;
  reg [63:0]          rec_dst;
  reg [31:0]          rd;
  reg [PW-1:0]        next_tos;
  integer             i;
  integer             wi;
  integer             ri;

  // Writes land with ack, the same edge at which the master completes.
  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wb_wr  = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;

  // ----------------------------------------------------------------------
  // Interrupt request
  // ----------------------------------------------------------------------
  always @* begin
    for (i = 0; i < NUM_GP; i = i + 1)
      gp_int_en[i] = evsel[i][`BRSF_EVSEL_INT_EN];  // RL6
    for (i = 0; i < NUM_FIX; i = i + 1)
      fix_int_en[i] = fix_ctl[i*`BRSF_FIX_FIELD_W + `BRSF_FIX_INT_BIT];  // RL7
  end

  wire gp_pmi  = |(gp_overflow_i & gp_int_en);  // RL6
  wire fix_pmi = |(fix_overflow_i & fix_int_en);  // RL7
  wire pmi_req = gp_pmi | fix_pmi | sampling_thresh_i | trace_thresh_i;  // RL8 RL9

  // ----------------------------------------------------------------------
  // Record capture
  // ----------------------------------------------------------------------
  wire rec_on = debug_ctl[`BRSF_DBG_REC_EN] | debug_ctl[`BRSF_DBG_TRACE_EN];  // RL23
  wire do_rec = ip_change_i & ~is_debug_exc_i & rec_on;  // RL11 RL21
  wire ext    = mode[`BRSF_MODE_EXT64];
  wire compat = mode[`BRSF_MODE_COMPAT];

  // Explicit wrap keeps the pointer inside 0 to DEPTH-1.
  always @* begin
    next_tos = top_of_stack_pointer + {{(PW-1){1'b0}}, 1'b1};  // RL24
    if (top_of_stack_pointer == DEPTH - 1)
      next_tos = {PW{1'b0}};  // RL10
  end

  always @* begin
    rec_src = brsf_shape(src_addr_i, ext, compat);  // RL14 RL15
    rec_dst = brsf_shape(dst_addr_i, ext, compat);  // RL14 RL15
    case (REC_FORMAT)
      `BRSF_FMT_EFF64_FLAGS: begin
        rec_src[63:`BRSF_FLAG_LSB] = rec_flags_i;  // RL17
      end
      `BRSF_FMT_PACKED32: begin
        rec_src = {dst_addr_i[31:0], src_addr_i[31:0]};  // RL18
        rec_dst = {dst_addr_i[31:0], src_addr_i[31:0]};  // RL18
      end
      default: begin
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (do_rec) begin
      src_mem[next_tos] <= rec_src;  // RL12 RL24
      dst_mem[next_tos] <= rec_dst;  // RL12
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      top_of_stack_pointer <= {PW{1'b0}};
    end else if (do_rec) begin
      top_of_stack_pointer <= next_tos;  // RL13 RL24
    end
  end

  // ----------------------------------------------------------------------
  // Last exception record
  // ----------------------------------------------------------------------
  // Only plain branches refresh the shadow copy, so an exception never
  // overwrites the branch that led into it before it is captured.
  always @(posedge clk_i) begin
    if (rst_i) begin
      last_src <= 64'h0000_0000_0000_0000;
      last_dst <= 64'h0000_0000_0000_0000;
    end else if (do_rec & ~is_exception_i) begin
      last_src <= brsf_shape(src_addr_i, ext, compat);
      last_dst <= brsf_shape(dst_addr_i, ext, compat);
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ler_src <= 64'h0000_0000_0000_0000;
      ler_dst <= 64'h0000_0000_0000_0000;
    end else if (ip_change_i & is_exception_i) begin
      ler_src <= last_src;  // RL19 RL20
      ler_dst <= last_dst;  // RL19 RL20
    end
  end

  // ----------------------------------------------------------------------
  // Control registers and freeze
  // ----------------------------------------------------------------------
  wire       wr_dbg    = wb_wr & (wb_adr_i == `BRSF_DBGCTL_OFS);
  wire       wr_gctl   = wb_wr & (wb_adr_i == `BRSF_GCTRL_OFS);
  wire       wr_fix    = wb_wr & (wb_adr_i == `BRSF_FIXCTL_OFS);
  wire       wr_mode   = wb_wr & (wb_adr_i == `BRSF_MODE_OFS) & wb_sel_i[0];
  wire       wr_status = wb_wr & (wb_adr_i == `BRSF_STATUS_OFS) & wb_sel_i[0];
  wire       frz_rec   = pmi_req & debug_ctl[`BRSF_DBG_FRZ_REC];  // RL1
  wire       frz_cnt   = pmi_req & debug_ctl[`BRSF_DBG_FRZ_CNT];  // RL4
  wire       dbg_stop  = ip_change_i & is_debug_exc_i;  // RL22
  wire [3:0] cause_now = {trace_thresh_i, sampling_thresh_i, fix_pmi, gp_pmi};

  // ----------------------------------------------------------------------
  // Debug control
  // ----------------------------------------------------------------------
  // Hardware clears win over a same-cycle software write, so a freeze
  // is never undone by a stale write racing the interrupt.
  always @(posedge clk_i) begin
    if (rst_i) begin
      debug_ctl <= `BRSF_DBGCTL_RST;
    end else begin
      if (wr_dbg)
        debug_ctl <= brsf_merge(debug_ctl, wb_dat_i, wb_sel_i);  // RL2 RL3
      if (frz_rec | dbg_stop)
        debug_ctl[`BRSF_DBG_REC_EN] <= 1'b0;  // RL1 RL22
    end
  end

  // ----------------------------------------------------------------------
  // Global counter control
  // ----------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      global_counter_control_o <= `BRSF_GCTRL_RST;
    end else if (frz_cnt) begin
      global_counter_control_o <= 32'h0000_0000;  // RL4
    end else if (wr_gctl) begin
      global_counter_control_o <= brsf_merge(global_counter_control_o, wb_dat_i,
                                             wb_sel_i);  // RL5
    end
  end

  // ----------------------------------------------------------------------
  // Counter event controls and mode
  // ----------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      fix_ctl <= 32'h0000_0000;
      mode    <= 2'h0;
      for (wi = 0; wi < NUM_GP; wi = wi + 1)
        evsel[wi] <= 32'h0000_0000;
    end else begin
      if (wr_fix)
        fix_ctl <= brsf_merge(fix_ctl, wb_dat_i, wb_sel_i);
      if (wr_mode)
        mode <= wb_dat_i[1:0];
      for (wi = 0; wi < NUM_GP; wi = wi + 1)
        if (wb_wr && brsf_evsel_hit(wb_adr_i, wi))
          evsel[wi] <= brsf_merge(evsel[wi], wb_dat_i, wb_sel_i);
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt cause status
  // ----------------------------------------------------------------------
  // A new cause in the same cycle as a clear wins, so no source is lost
  // to a handler acknowledging an older one.
  always @(posedge clk_i) begin
    if (rst_i) begin
      pmi_cause <= 4'h0;
    end else if (wr_status) begin
      pmi_cause <= (pmi_cause & ~wb_dat_i[3:0]) | cause_now;
    end else begin
      pmi_cause <= pmi_cause | cause_now;
    end
  end

  // ----------------------------------------------------------------------
  // Status outputs
  // ----------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      perf_monitor_interrupt_o <= 1'b0;
      branch_record_stack_en_o <= 1'b0;
    end else begin
      perf_monitor_interrupt_o <= pmi_req;  // RL6 RL7 RL8 RL9
      branch_record_stack_en_o <= rec_on;
    end
  end

  // ----------------------------------------------------------------------
  // Wishbone read and acknowledge
  // ----------------------------------------------------------------------
  // Stack windows: 8 bytes per entry, low word first. The arrays carry
  // no reset, so only entries written since power-up read as defined.
  wire [11:0]   adr_src = wb_adr_i - `BRSF_SRC_BASE_OFS;
  wire [11:0]   adr_dst = wb_adr_i - `BRSF_DST_BASE_OFS;
  wire          src_hit = (adr_src[11:10] == 2'b00) && (adr_src[9:3] < DEPTH);  // RL12
  wire          dst_hit = (adr_dst[11:10] == 2'b00) && (adr_dst[9:3] < DEPTH);  // RL12
  wire [PW-1:0] src_idx = adr_src[PW+2:3];
  wire [PW-1:0] dst_idx = adr_dst[PW+2:3];

  always @* begin
    rd = 32'h0000_0000;
    case (wb_adr_i)
      `BRSF_DBGCTL_OFS:     rd = debug_ctl;
      `BRSF_GCTRL_OFS:      rd = global_counter_control_o;
      `BRSF_FIXCTL_OFS:     rd = fix_ctl;
      `BRSF_TOS_OFS:        rd = {{(32-PW){1'b0}}, top_of_stack_pointer};  // RL13
      `BRSF_CAPS_OFS:       rd = {26'h0000000, REC_FORMAT};  // RL16
      `BRSF_MODE_OFS:       rd = {30'h00000000, mode};
      `BRSF_STATUS_OFS:     rd = {28'h0000000, pmi_cause};
      `BRSF_LER_SRC_LO_OFS: rd = ler_src[31:0];
      `BRSF_LER_SRC_HI_OFS: rd = ler_src[63:32];
      `BRSF_LER_DST_LO_OFS: rd = ler_dst[31:0];
      `BRSF_LER_DST_HI_OFS: rd = ler_dst[63:32];
      default: begin
        for (ri = 0; ri < NUM_GP; ri = ri + 1)
          if (brsf_evsel_hit(wb_adr_i, ri))
            rd = evsel[ri];
        if (src_hit)
          rd = adr_src[2] ? src_mem[src_idx][63:32] : src_mem[src_idx][31:0];
        if (dst_hit)
          rd = adr_dst[2] ? dst_mem[dst_idx][63:32] : dst_mem[dst_idx][31:0];
      end
    endcase
  end

  // Data is zero outside ack, so an idle bus never shows a stale word.
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd : 32'h0000_0000;
    end
  end

endmodule

//--- tb/brsf_monitor.sv
// Port-level checks for the branch record stack freeze unit.
// Assumes one clock, synchronous reset, bound onto brsf_top.
`timescale 1ns/10ps
module brsf_monitor #(
  parameter NUM_GP  = 4,
  parameter NUM_FIX = 3
) (
  input wire               clk_i,
  input wire               rst_i,
  input wire               wb_cyc_i,
  input wire               wb_stb_i,
  input wire               wb_we_i,
  input wire [31:0]        wb_dat_o,
  input wire               wb_ack_o,
  input wire [NUM_GP-1:0]  gp_overflow_i,
  input wire [NUM_FIX-1:0] fix_overflow_i,
  input wire               sampling_thresh_i,
  input wire               trace_thresh_i,
  input wire               perf_monitor_interrupt_o,
  input wire [31:0]        global_counter_control_o,
  input wire               branch_record_stack_en_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ack_resp; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("ack not one cycle after request");
  property p_ack_src; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
  a_ack_src: assert property (p_ack_src) else $error("ack without request");
  property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
  property p_samp_int; sampling_thresh_i |=> perf_monitor_interrupt_o; endproperty
  a_samp_int: assert property (p_samp_int) else $error("no interrupt on sampling");
  property p_trace_int; trace_thresh_i |=> perf_monitor_interrupt_o; endproperty
  a_trace_int: assert property (p_trace_int) else $error("no interrupt on trace");
  property p_int_cause; perf_monitor_interrupt_o |->
    $past(|{gp_overflow_i, fix_overflow_i, sampling_thresh_i, trace_thresh_i}); endproperty
  a_int_cause: assert property (p_int_cause) else $error("interrupt without cause");
  // Write may land with ack or one edge later
  property p_gctl_src; !$stable(global_counter_control_o) |-> perf_monitor_interrupt_o ||
    (wb_ack_o && wb_we_i) || $past(wb_ack_o && wb_we_i); endproperty
  a_gctl_src: assert property (p_gctl_src) else $error("counter enables moved alone");
  property p_en_rise; $rose(branch_record_stack_en_o) |->
    $past(wb_ack_o && wb_we_i) || $past(wb_ack_o && wb_we_i, 2); endproperty
  a_en_rise: assert property (p_en_rise) else $error("recording enabled alone");
endmodule
bind brsf_top brsf_monitor #(.NUM_GP(NUM_GP), .NUM_FIX(NUM_FIX)) u_mon (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .gp_overflow_i(gp_overflow_i),
  .fix_overflow_i(fix_overflow_i), .sampling_thresh_i(sampling_thresh_i),
  .trace_thresh_i(trace_thresh_i), .perf_monitor_interrupt_o(perf_monitor_interrupt_o),
  .global_counter_control_o(global_counter_control_o),
  .branch_record_stack_en_o(branch_record_stack_en_o));

//--- tb/brsf_tb_top.sv
// Self-checking bench for the branch record stack freeze unit.
// Assumes brsf_top with byte offsets from brsf_defines.vh.
`timescale 1ns/10ps
`include "brsf_defines.vh"
module brsf_tb_top;
  localparam D = 8;
  logic        clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [11:0] wb_adr_i = 0;
  logic [31:0] wb_dat_i = 0, wb_dat_o, global_counter_control_o, q, g;
  logic [3:0]  wb_sel_i = 4'hF, gp_overflow_i = 0;
  logic        wb_ack_o, perf_monitor_interrupt_o, branch_record_stack_en_o;
  logic        ip_change_i = 0, is_exception_i = 0, is_debug_exc_i = 0;
  logic        sampling_thresh_i = 0, trace_thresh_i = 0;
  logic [63:0] src_addr_i = 0, dst_addr_i = 0, src_m [D], dst_m [D], ls, ld, es, ed;
  logic [5:0]  rec_flags_i = 0;
  logic [2:0]  fix_overflow_i = 0;
  logic [1:0]  mode = 0;
  int          num_errors = 0, comparisons = 0, tos_m = 0, seed = 32'h2ead0056;
  always #4 clk_i = ~clk_i;
  brsf_top #(.DEPTH(D)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ip_change_i(ip_change_i),
    .is_exception_i(is_exception_i), .is_debug_exc_i(is_debug_exc_i), .src_addr_i(src_addr_i),
    .dst_addr_i(dst_addr_i), .rec_flags_i(rec_flags_i), .gp_overflow_i(gp_overflow_i),
    .fix_overflow_i(fix_overflow_i), .sampling_thresh_i(sampling_thresh_i),
    .trace_thresh_i(trace_thresh_i), .perf_monitor_interrupt_o(perf_monitor_interrupt_o),
    .global_counter_control_o(global_counter_control_o),
    .branch_record_stack_en_o(branch_record_stack_en_o));
  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function logic [63:0] cut(input logic [63:0] a);
    return (mode == 2'b01) ? a : {32'h0, a[31:0]};
  endfunction
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task bus(input logic we, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 40);
    if (n >= 40) num_errors++;
    q = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    bus(0, a, 0);
    chk(q, e);
  endtask
  // One pointer change; model follows only when recording is expected
  task ev(input logic exc, input logic dbg, input logic rec);
    logic [63:0] s, d;
    s = {$random(seed), $random(seed)};
    d = {$random(seed), $random(seed)};
    @(posedge clk_i);
    ip_change_i    <= 1;
    is_exception_i <= exc;
    is_debug_exc_i <= dbg;
    src_addr_i     <= s;
    dst_addr_i     <= d;
    rec_flags_i    <= $random(seed);
    @(posedge clk_i);
    ip_change_i <= 0;
    if (rec) begin
      tos_m = (tos_m + 1) % D;
      src_m[tos_m] = cut(s);
      dst_m[tos_m] = cut(d);
      if (exc) {es, ed} = {ls, ld};
      else {ls, ld} = {cut(s), cut(d)};
    end
  endtask
  task print_verdict;
    if (num_errors == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #400000;
    num_errors++;
    print_verdict;
  end
  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 0;
    rd(`BRSF_DBGCTL_OFS, 32'h0);
    rd(`BRSF_GCTRL_OFS, 32'h0);
    bus(1, `BRSF_CAPS_OFS, 32'h3F);
    rd(`BRSF_CAPS_OFS, {26'h0, `BRSF_FMT_LIN64});
    rd(12'hFF0, 32'h0);
    for (int m = 0; m < 4; m++) begin
      mode = 2'(m) ^ 2'b10;
      bus(1, `BRSF_MODE_OFS, {30'h0, mode});
      bus(1, `BRSF_DBGCTL_OFS, 32'h1);
      repeat (3) ev(0, 0, 1);
      ev(1, 0, 1);
      rd(`BRSF_LER_SRC_LO_OFS, es[31:0]);
      rd(`BRSF_LER_SRC_HI_OFS, es[63:32]);
      rd(`BRSF_LER_DST_LO_OFS, ed[31:0]);
      rd(`BRSF_LER_DST_HI_OFS, ed[63:32]);
    end
    rd(`BRSF_TOS_OFS, tos_m);
    for (int i = 0; i < D; i++) begin
      rd(`BRSF_SRC_BASE_OFS + 12'(8 * i), src_m[i][31:0]);
      rd(`BRSF_SRC_BASE_OFS + 12'(8 * i + 4), src_m[i][63:32]);
      rd(`BRSF_DST_BASE_OFS + 12'(8 * i), dst_m[i][31:0]);
      rd(`BRSF_DST_BASE_OFS + 12'(8 * i + 4), dst_m[i][63:32]);
    end
    ev(0, 1, 0);
    rd(`BRSF_DBGCTL_OFS, 32'h0);
    chk(branch_record_stack_en_o, 0);
    rd(`BRSF_TOS_OFS, tos_m);
    bus(1, `BRSF_DBGCTL_OFS, 32'h40);
    ev(0, 0, 1);
    rd(`BRSF_TOS_OFS, tos_m);
    chk(branch_record_stack_en_o, 1);
    // Case 4 overflows a counter whose interrupt is not enabled
    for (int c = 0; c < 5; c++) begin
      g = ($random(seed) & 32'hF) | 32'h1;
      bus(1, `BRSF_DBGCTL_OFS, 32'h1801);
      bus(1, `BRSF_GCTRL_OFS, g);
      bus(1, `BRSF_EVSEL_OFS, (c == 4) ? 32'h0 : 32'h0010_0000);
      bus(1, `BRSF_FIXCTL_OFS, 32'h4);
      @(posedge clk_i);
      gp_overflow_i[0]  <= (c == 0 || c == 4);
      fix_overflow_i[0] <= (c == 1);
      sampling_thresh_i <= (c == 2);
      trace_thresh_i    <= (c == 3);
      @(posedge clk_i);
      gp_overflow_i     <= 0;
      fix_overflow_i    <= 0;
      sampling_thresh_i <= 0;
      trace_thresh_i    <= 0;
      #1 chk(perf_monitor_interrupt_o, c != 4);
      chk(global_counter_control_o, (c == 4) ? g : 32'h0);
      rd(`BRSF_DBGCTL_OFS, (c == 4) ? 32'h1801 : 32'h1800);
      ev(0, 0, c == 4);
      rd(`BRSF_TOS_OFS, tos_m);
      rd(`BRSF_STATUS_OFS, (c == 4) ? 32'h0 : (32'h1 << c));
      bus(1, `BRSF_STATUS_OFS, 32'hF);
      rd(`BRSF_STATUS_OFS, 32'h0);
    end
    print_verdict;
  end
endmodule
